// *** logic/sbf_pkg.sv ***
package sbf_pkg;

  // ****************************************************************
  // register bus
  // ****************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 4'h1;

  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ENABLE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE    = 8'h00;
  localparam logic [DATA_W-1:0] ALL_ONES     = 8'hff;

  // ****************************************************************
  // field layout: each buffer owns a group of three bits
  // ****************************************************************
  localparam int unsigned NUM_BUF = 2;
  localparam int unsigned BUF_RX  = 0;
  localparam int unsigned BUF_TX  = 1;

  localparam int unsigned GRP_W = 3;

  // offsets inside a group
  localparam int unsigned FLD_SLIP  = 0;
  localparam int unsigned FLD_EMPTY = 1;
  localparam int unsigned FLD_FULL  = 2;

  // base bit of each group
  localparam int unsigned BASE_RX = 0;
  localparam int unsigned BASE_TX = 5;

  // implemented bits; bits 4 and 3 read as zero
  localparam logic [DATA_W-1:0] FLAG_MASK = 8'he7;

  typedef logic [GRP_W-1:0] sbf_grp_t;

endpackage

// *** logic/sbf_slip_detect.sv ***
`timescale 1ns/1ns

// ****************************************************************
// per-buffer slip event detector
// ****************************************************************
module sbf_slip_detect
  import sbf_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // buffer state and accesses
  input  wire logic full_i,
  input  wire logic empty_i,
  input  wire logic wr_access_i,
  input  wire logic rd_access_i,
  // events to the flag register
  output logic      full_evt_o,
  output logic      empty_evt_o,
  // frame slip commands to the datapath
  output logic      repeat_frame_o,
  output logic      discard_frame_o
);

  typedef struct packed {
    logic prev_full;
    logic prev_empty;
    logic repeat_frame;
    logic discard_frame;
  } sbf_det_s;

  sbf_det_s state_reg;
  sbf_det_s state_next;

  logic     overrun;
  logic     underrun;

  always_comb begin
    overrun    = full_i & wr_access_i;
    underrun   = empty_i & rd_access_i;
    state_next = state_reg;
    state_next.prev_full     = full_i;
    state_next.prev_empty    = empty_i;
    state_next.discard_frame = overrun;
    state_next.repeat_frame  = underrun;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // buffer becoming full or empty, or an access that forces a slip
  assign full_evt_o      = (full_i & ~state_reg.prev_full) | overrun;
  assign empty_evt_o     = (empty_i & ~state_reg.prev_empty) | underrun;
  assign repeat_frame_o  = state_reg.repeat_frame;
  assign discard_frame_o = state_reg.discard_frame;

endmodule

// *** logic/sbf_slip_flags.sv ***
// Overview of operation
// - rx empty flag reads 1 if empty event since last status read; read clears it
// - rx empty event is declared whenever the receive store becomes empty
// - read of empty rx store replays a whole frame and sets the empty flag
// - rx slip flag sets on fill or empty, including replay; cleared by read
// - enable bit 7 is read/write tx full interrupt enable, reset 0
// - write to full tx store discards a whole frame and sets tx full flag
// - tx full interrupt raised only while its enable bit is 1
// - write to full rx store discards a whole frame and sets flag bit 2
`timescale 1ns/1ns

module sbf_slip_flags
  import sbf_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // receive elastic store
  input  wire logic              rx_full_i,
  input  wire logic              rx_empty_i,
  input  wire logic              rx_wr_access_i,
  input  wire logic              rx_rd_access_i,
  output logic                   rx_repeat_frame_o,
  output logic                   rx_discard_frame_o,
  // transmit elastic store
  input  wire logic              tx_full_i,
  input  wire logic              tx_empty_i,
  input  wire logic              tx_wr_access_i,
  input  wire logic              tx_rd_access_i,
  output logic                   tx_repeat_frame_o,
  output logic                   tx_discard_frame_o,
  // interrupt request
  output logic                   irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  // status flags, enables, and the read word that stands for one cycle
  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] enable;
    logic [DATA_W-1:0] rdata;
  } sbf_regs_s;

  sbf_regs_s regs_reg;
  sbf_regs_s regs_next;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // event group: slip is set by either full or empty
  function automatic sbf_grp_t grp_events(input logic full, input logic empty);
    sbf_grp_t g;
    g            = '0;
    g[FLD_FULL]  = full;
    g[FLD_EMPTY] = empty;
    g[FLD_SLIP]  = full | empty;
    return g;
  endfunction

  // spreads a group's bits into a register word at the given base bit
  function automatic logic [DATA_W-1:0] place_grp(input sbf_grp_t g, input int unsigned base);
    logic [DATA_W-1:0] v;
    v = '0;
    for (int unsigned i = 0; i < GRP_W; i++) begin
      v[base+i] = g[i];
    end
    return v;
  endfunction

  // base bit of a buffer's group in the status and enable registers
  function automatic int unsigned grp_base(input int unsigned buf_idx);
    int unsigned base;
    base = BASE_RX;
    if (buf_idx == BUF_TX) begin
      base = BASE_TX;
    end
    return base;
  endfunction

  // strobe that reaches one register: high only when the address selects it
  function automatic logic strobe_to(input logic strobe, input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] reg_addr);
    return strobe & (addr == reg_addr);
  endfunction

  // word returned by a read; unmapped addresses read as zero
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] addr, input sbf_regs_s regs);
    logic [DATA_W-1:0] w;
    w = READ_IDLE;
    if (addr == ADDR_STATUS) begin
      w = regs.status;
    end else if (addr == ADDR_ENABLE) begin
      w = regs.enable;
    end
    return w;
  endfunction

  // ****************************************************************
  // per-buffer detectors
  // ****************************************************************
  logic [NUM_BUF-1:0] buf_full;
  logic [NUM_BUF-1:0] buf_empty;
  logic [NUM_BUF-1:0] buf_wr;
  logic [NUM_BUF-1:0] buf_rd;
  logic [NUM_BUF-1:0] full_evt;
  logic [NUM_BUF-1:0] empty_evt;
  logic [NUM_BUF-1:0] repeat_frame;
  logic [NUM_BUF-1:0] discard_frame;
  // flag bits that each buffer raises this cycle, at its own group
  logic [DATA_W-1:0]  buf_set [NUM_BUF];

  assign buf_full  = {tx_full_i, rx_full_i};
  assign buf_empty = {tx_empty_i, rx_empty_i};
  assign buf_wr    = {tx_wr_access_i, rx_wr_access_i};
  assign buf_rd    = {tx_rd_access_i, rx_rd_access_i};

  // levels are compared with the previous cycle, so a store that is already
  // full or empty when reset ends reports that event in the first cycle
  genvar b;
  generate
    for (b = 0; b < NUM_BUF; b++) begin : g_buf
      sbf_slip_detect u_detect (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .full_i          (buf_full[b]),
        .empty_i         (buf_empty[b]),
        .wr_access_i     (buf_wr[b]),
        .rd_access_i     (buf_rd[b]),
        .full_evt_o      (full_evt[b]),
        .empty_evt_o     (empty_evt[b]),
        .repeat_frame_o  (repeat_frame[b]),
        .discard_frame_o (discard_frame[b])
      );

      assign buf_set[b] = place_grp(grp_events(full_evt[b], empty_evt[b]),
                                    grp_base(b));
    end
  endgenerate

  // frame slip commands go straight to each store's datapath
  assign rx_repeat_frame_o  = repeat_frame[BUF_RX];
  assign rx_discard_frame_o = discard_frame[BUF_RX];
  assign tx_repeat_frame_o  = repeat_frame[BUF_TX];
  assign tx_discard_frame_o = discard_frame[BUF_TX];

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic              rd_status;
  logic              wr_status;
  logic              wr_enable;

  // strobes qualified by the register they address; other addresses do nothing
  assign rd_status = strobe_to(rd_i, addr_i, ADDR_STATUS);
  assign wr_status = strobe_to(wr_i, addr_i, ADDR_STATUS);
  assign wr_enable = strobe_to(wr_i, addr_i, ADDR_ENABLE);

  // ****************************************************************
  // register update
  // ****************************************************************
  logic [DATA_W-1:0] set_bits;
  logic [DATA_W-1:0] clr_bits;

  always_comb begin
    // flags raised by either buffer in this cycle
    set_bits = '0;
    for (int unsigned k = 0; k < NUM_BUF; k++) begin
      set_bits = set_bits | buf_set[k];
    end

    // a status read clears all flags, a write of ones clears the chosen flags
    clr_bits = READ_IDLE;
    if (rd_status) begin
      clr_bits = ALL_ONES;
    end else if (wr_status) begin
      clr_bits = wdata_i;
    end

    regs_next = regs_reg;
    // a new event wins over a clear in the same cycle
    regs_next.status = ((regs_reg.status & ~clr_bits) | set_bits) & FLAG_MASK;

    if (wr_enable) begin
      regs_next.enable = wdata_i & FLAG_MASK;
    end

    // read data stand for exactly one cycle
    regs_next.rdata = READ_IDLE;
    if (rd_i) begin
      regs_next.rdata = read_word(addr_i, regs_reg);
    end
  end

  // reset clears flags, enables and the read word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      regs_reg.status <= STATUS_RESET;
      regs_reg.enable <= ENABLE_RESET;
      regs_reg.rdata  <= READ_IDLE;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_o = regs_reg.rdata;
  // flags that are both raised and enabled
  logic [DATA_W-1:0] pending;
  assign pending = regs_reg.status & regs_reg.enable;
  assign irq_o   = |pending;

endmodule

// *** verif/sbf_slip_monitor.sv ***
`timescale 1ns/1ns
module sbf_slip_monitor
  import sbf_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              rx_full_i,
  input wire logic              rx_empty_i,
  input wire logic              rx_wr_access_i,
  input wire logic              rx_rd_access_i,
  input wire logic              rx_repeat_frame_o,
  input wire logic              rx_discard_frame_o,
  input wire logic              tx_full_i,
  input wire logic              tx_empty_i,
  input wire logic              tx_wr_access_i,
  input wire logic              tx_rd_access_i,
  input wire logic              tx_discard_frame_o,
  input wire logic              irq_o
);
  logic rs;
  assign rs = rd_i && addr_i == ADDR_STATUS;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rx_repeat_pulse: assert property (rx_empty_i && rx_rd_access_i |=> rx_repeat_frame_o)
    else $error("rx repeat pulse missing");
  a_rx_discard_pulse: assert property (rx_full_i && rx_wr_access_i |=> rx_discard_frame_o)
    else $error("rx discard pulse missing");
  a_tx_discard_pulse: assert property (tx_full_i && tx_wr_access_i |=> tx_discard_frame_o)
    else $error("tx discard pulse missing");
  a_rx_full_flag: assert property (rx_full_i && rx_wr_access_i ##1 rs |=> rdata_o[2] && rdata_o[0])
    else $error("rx full flag not reported");
  a_rx_empty_flag: assert property ($rose(rx_empty_i) ##1 rs |=> rdata_o[1] && rdata_o[0])
    else $error("rx empty flag not reported");
  a_read_clears: assert property (rs && !$past(rst_i)
    && !(rx_wr_access_i || rx_rd_access_i || tx_wr_access_i || tx_rd_access_i)
    && $stable({rx_full_i, rx_empty_i, tx_full_i, tx_empty_i}) ##1 rs |=> rdata_o == 8'h00)
    else $error("status not cleared by read");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_irq_disabled: assert property (wr_i && addr_i == ADDR_ENABLE && wdata_i == 8'h00 |=> !irq_o)
    else $error("irq high with all enables off");
endmodule

bind sbf_slip_flags sbf_slip_monitor u_mon (.*);

// *** verif/sbf_store_model.sv ***
`timescale 1ns/1ns
// two-frame elastic store; a slip keeps the fill at its limit
module sbf_store_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic wr_req_i,
  input  wire logic rd_req_i,
  output logic      full_o,
  output logic      empty_o,
  output logic      wr_access_o,
  output logic      rd_access_o
);
  logic [1:0] fill_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) fill_reg <= 2'h1;
    else if (wr_req_i && !rd_req_i && fill_reg != 2'h2) fill_reg <= fill_reg + 2'h1;
    else if (rd_req_i && !wr_req_i && fill_reg != 2'h0) fill_reg <= fill_reg - 2'h1;
  end
  assign full_o      = fill_reg == 2'h2;
  assign empty_o     = fill_reg == 2'h0;
  assign wr_access_o = wr_req_i;
  assign rd_access_o = rd_req_i;
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ns
module testbench
  import sbf_pkg::*;
;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, rd_q = 0, irq;
  logic [3:0] addr = 0, acc = 0;
  logic [7:0] wdata = 0, rdata, exp_q[$];
  logic       rxf, rxe, rxw, rxr, txf, txe, txw, txr;
  int         seed = 13, fails = 0, checks_done = 0;
  always #5 clk = ~clk;
  sbf_store_model u_rx (.clk_i(clk), .rst_i(rst), .wr_req_i(acc[3]), .rd_req_i(acc[2]),
    .full_o(rxf), .empty_o(rxe), .wr_access_o(rxw), .rd_access_o(rxr));
  sbf_store_model u_tx (.clk_i(clk), .rst_i(rst), .wr_req_i(acc[1]), .rd_req_i(acc[0]),
    .full_o(txf), .empty_o(txe), .wr_access_o(txw), .rd_access_o(txr));
  sbf_slip_flags u_dut (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .rx_full_i(rxf), .rx_empty_i(rxe), .rx_wr_access_i(rxw),
    .rx_rd_access_i(rxr), .rx_repeat_frame_o(), .rx_discard_frame_o(), .tx_full_i(txf),
    .tx_empty_i(txe), .tx_wr_access_i(txw), .tx_rd_access_i(txr), .tx_repeat_frame_o(),
    .tx_discard_frame_o(), .irq_o(irq));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one bus and store cycle; every input is assigned exactly once per cycle
  task step(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d,
            input logic [3:0] s, input logic [7:0] e);
    wr <= w; rd <= r; addr <= a; wdata <= d; acc <= s;
    if (r) exp_q.push_back(e);
    @(posedge clk);
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_q) chk(rdata, exp_q.pop_front());
    rd_q <= rd;
  end
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    step(0, 1, ADDR_ENABLE, 0, 0, ENABLE_RESET);
    step(0, 1, ADDR_STATUS, 0, 0, STATUS_RESET);
    step(1, 0, ADDR_ENABLE, ALL_ONES, 0, 0);
    step(0, 1, ADDR_ENABLE, 0, 0, FLAG_MASK);
    step(1, 0, 4'h2 + 4'($unsigned($random(seed)) % 6), 8'($random(seed)), 0, 0);
    step(0, 1, 4'h9, 0, 0, READ_IDLE);
    step(0, 1, ADDR_ENABLE, 0, 0, FLAG_MASK);
    repeat (3) step(0, 0, 0, 8'($random(seed)), 4'h8, 0);
    chk({7'h00, irq}, 8'h01);
    step(0, 1, ADDR_STATUS, 0, 0, 8'h05);
    step(0, 1, ADDR_STATUS, 0, 0, 8'h00);
    chk({7'h00, irq}, 8'h00);
    repeat (3) step(0, 0, 0, 8'($random(seed)), 4'h4, 0);
    step(0, 1, ADDR_STATUS, 0, 0, 8'h03);
    step(1, 0, ADDR_ENABLE, 8'h00, 0, 0);
    repeat (3) step(0, 0, 0, 8'($random(seed)), 4'h2, 0);
    chk({7'h00, irq}, 8'h00);
    step(1, 0, ADDR_ENABLE, 8'h80, 0, 0);
    step(0, 1, ADDR_STATUS, 0, 0, 8'ha0);
    chk({7'h00, irq}, 8'h01);
    step(0, 0, 0, 0, 0, 0);
    chk({7'h00, irq}, 8'h00);
    // write of ones clears only those flags; an event beside a read survives it
    step(0, 0, 0, 0, 4'h2, 0);
    step(1, 0, ADDR_STATUS, 8'h80, 0, 0);
    step(0, 1, ADDR_STATUS, 0, 4'h2, 8'h20);
    step(0, 1, ADDR_STATUS, 0, 0, 8'ha0);
    repeat (2) step(0, 0, 0, 0, 0, 0);
    give_verdict();
  end
endmodule
